// ### rtl/sgc_consts.svh
// Offsets, field positions, reset values and timing counts of the global control block
`ifndef SGC_CONSTS_SVH
`define SGC_CONSTS_SVH

// Register indices; byte address is four times the index
`define SGC_IDX_GC0 6'h02
`define SGC_IDX_GC1 6'h03

// Global control zero fields
`define SGC_GC0_LINK_AGE 0
`define SGC_GC0_CTRL_SEL 1
`define SGC_GC0_SHARE 2
`define SGC_GC0_RST 3'h4

// Global control one fields
`define SGC_GC1_BACKOFF 0
`define SGC_GC1_FAST_AGE 1
`define SGC_GC1_AGING 2
`define SGC_GC1_LEN_CHK 3
`define SGC_GC1_RX_PAUSE_DIS 4
`define SGC_GC1_TX_PAUSE_DIS 5
`define SGC_GC1_PASS_ALL 7
`define SGC_GC1_RST 8'h04

// Frame fields
`define SGC_MAC_CTRL_TYPE 16'h8808
`define SGC_PAUSE_DA 48'h0180c2000001
`define SGC_LEN_LIMIT 16'd1500

// Timing
`define SGC_CLK_HZ 64'd20000000
`define SGC_CLK_PERIOD_NS 64'd50
`define SGC_NORMAL_AGE_S 64'd300
`define SGC_FAST_AGE_NS 64'd800000
`define SGC_NORMAL_AGE_CYC (`SGC_NORMAL_AGE_S * `SGC_CLK_HZ)
`define SGC_FAST_AGE_CYC (`SGC_FAST_AGE_NS / `SGC_CLK_PERIOD_NS)

// Strap capture point after reset release
`define SGC_STRAP_LOAD_CNT 2'h2
`define SGC_STRAP_DONE_CNT 2'h3

// Sizes
`define SGC_NUM_PORTS 5
`define SGC_AGE_CNT_W 33
`define SGC_POOL_DIV 16'd5

`endif

// ### rtl/sgc_global_ctrl.sv
// Global control registers of the switch with aging, pause and frame drop policy
//
// Behaviour
// - Share bit: whole pool, else one fifth
// - Drop select set: drop 8808 or pause DA
// - Drop select clear: drop qualified pause frames
// - Link drop with enable: one fast age
// - Any unplugged port flushes all addresses
// - Pass all forwards every frame, errored too
// - Bit five blocks transmit pause from negotiation
// - Bit four blocks receive pause from negotiation
// - One strap presets both pause disable bits
// - Length check drops mismatching short frames
// - Bit two enables aging, strap default on
// - Fast age bit uses short period
// - Bit zero selects aggressive back off
//
// Our own choice: the Wishbone slave port.
`include "sgc_consts.svh"

module sgc_global_ctrl #(
    parameter logic [`SGC_AGE_CNT_W-1:0] NORMAL_AGE_CYC = `SGC_AGE_CNT_W'(`SGC_NORMAL_AGE_CYC),
    parameter logic [`SGC_AGE_CNT_W-1:0] FAST_AGE_CYC = `SGC_AGE_CNT_W'(`SGC_FAST_AGE_CYC),
    parameter logic [15:0] POOL_BLOCKS = 16'd500
) (
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Strap pins, sampled after reset
    input wire logic pause_disable_strap_pin,
    input wire logic backoff_strap_pin,
    input wire logic aging_strap_pin,
    // Port status from the PHY logic on this clock
    input wire sgc_pkg::sgc_port_t linkUp,
    input wire sgc_pkg::sgc_port_t anTxPause,
    input wire sgc_pkg::sgc_port_t anRxPause,
    // Received frame header for the drop decision
    input wire logic frmValid,
    input wire logic [15:0] frmTypeLen,
    input wire logic [47:0] frmDstAddr,
    input wire logic [15:0] frmLen,
    input wire logic frmErr,
    input wire logic frmPauseQual,
    output logic frmDone,
    output logic frmDrop,
    // Policy outputs to the switch core
    output logic [15:0] portBufLimit,
    output logic bufShareEn,
    output logic passAllFrames,
    output logic aggressiveBackoff,
    output sgc_pkg::sgc_port_t txPauseEn,
    output sgc_pkg::sgc_port_t rxPauseEn,
    output logic agingEn,
    output logic ageTick,
    output logic ageFast,
    output logic ageFlushAll
);
    import sgc_pkg::*;

    sgc_state_s st_ff;
    sgc_state_s nxt_st;
    logic [2:0] strapSync;
    logic [5:0] regIdx;
    logic busReq;
    logic busWrite;
    logic linkDrop;
    logic typeHit;
    logic addrHit;
    logic ctrlHit;
    logic lenBad;
    logic dropNow;
    logic ageEnd;
    logic onceStart;
    logic strapLoad;
    wire sgc_port_t linkFall;
    wire sgc_port_t txGate;
    wire sgc_port_t rxGate;
    sgc_age_cnt_t agePeriod;

    // Ceilings per port; the split share rounds down, so a few pool blocks may sit unused
    localparam logic [15:0] SHARED_LIMIT = POOL_BLOCKS;
    localparam logic [15:0] SPLIT_LIMIT = POOL_BLOCKS / `SGC_POOL_DIV;
    // With fast aging off, the cycle after a link drop runs one count short so it stays under the fast bound
    localparam sgc_age_cnt_t ONCE_AGE_CYC = FAST_AGE_CYC - `SGC_AGE_CNT_W'(1);
    // Three strap pins pass the synchroniser together
    localparam int STRAP_W = 3;

    // Strap pins come from outside and pass two flip-flops first
    sgc_sync #(
        .WIDTH(STRAP_W)
    ) sgc_sync_inst (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({aging_strap_pin, backoff_strap_pin, pause_disable_strap_pin}),
        .syncOut(strapSync)
    );

    // True for the two implemented register indices
    function automatic logic isMapped(input logic [5:0] idx);
        isMapped = (idx == `SGC_IDX_GC0) || (idx == `SGC_IDX_GC1);
    endfunction

    // Read value of an index; unmapped words and upper bits read zero
    function automatic logic [7:0] readReg(input logic [5:0] idx, input logic [2:0] gc0,
                                           input logic [7:0] gc1);
        if (idx == `SGC_IDX_GC0) begin
            // Upper five bits are not stored and read zero
            readReg = {5'h00, gc0};
        end else if (idx == `SGC_IDX_GC1) begin
            readReg = gc1;
        end else begin
            readReg = 8'h00;
        end
    endfunction

    // Bus request decode; accesses wait until the straps are in
    assign regIdx = wb_adr_i[7:2];
    assign busReq = wb_cyc_i && wb_stb_i && !st_ff.ack && st_ff.strapDone;

    // A write lands at the edge that shows ack, while the master still holds address and data
    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && st_ff.ack && wb_sel_i[0] &&
                      isMapped(regIdx);

    // Per port copies of the pause gates and the link fall detect
    for (genvar p = 0; p < `SGC_NUM_PORTS; p++) begin : g_port
        assign txGate[p] = anTxPause[p] && !st_ff.gc1[`SGC_GC1_TX_PAUSE_DIS];
        assign rxGate[p] = anRxPause[p] && !st_ff.gc1[`SGC_GC1_RX_PAUSE_DIS];
        // A fall needs a link seen the cycle before, so none follows reset
        assign linkFall[p] = st_ff.linkPrev[p] && !linkUp[p];
    end

    assign linkDrop = |linkFall;

    assign typeHit = (frmTypeLen == `SGC_MAC_CTRL_TYPE);
    assign addrHit = (frmDstAddr == `SGC_PAUSE_DA);

    // Control frame match depends on the drop select bit
    always_comb begin
        ctrlHit = 1'b0;
        if (st_ff.gc0[`SGC_GC0_CTRL_SEL]) begin
            ctrlHit = typeHit || addrHit;
        end else begin
            ctrlHit = frmPauseQual;
        end
    end

    assign lenBad = st_ff.gc1[`SGC_GC1_LEN_CHK] && (frmTypeLen < `SGC_LEN_LIMIT) &&
                    (frmTypeLen != frmLen);

    // pass all overrides every drop reason
    assign dropNow = !st_ff.gc1[`SGC_GC1_PASS_ALL] && (ctrlHit || lenBad || frmErr);

    // Period of the running age cycle
    always_comb begin
        if (st_ff.gc1[`SGC_GC1_FAST_AGE]) begin
            agePeriod = FAST_AGE_CYC;
        end else if (st_ff.ageState == AGE_FAST_ONCE) begin
            agePeriod = ONCE_AGE_CYC;
        end else begin
            // Five minute period in normal use
            agePeriod = NORMAL_AGE_CYC;
        end
    end

    // End of the age cycle; compare with period minus one so ticks are a period apart
    assign ageEnd = st_ff.ageCnt >= agePeriod - `SGC_AGE_CNT_W'(1);
    assign onceStart = linkDrop && st_ff.gc0[`SGC_GC0_LINK_AGE];

    assign strapLoad = !st_ff.strapDone && (st_ff.strapCnt == `SGC_STRAP_LOAD_CNT);

    // Next state of the whole block
    always_comb begin
        nxt_st = st_ff;
        // Pulses fall back low every cycle unless set below
        nxt_st.ack = 1'b0;
        nxt_st.ageTick = 1'b0;
        nxt_st.flushAll = 1'b0;
        nxt_st.frmDone = 1'b0;
        nxt_st.frmDrop = 1'b0;

        // Strap fill counter; it stops once strapDone is set, a cycle after the straps are loaded
        if (!st_ff.strapDone) begin
            nxt_st.strapCnt = st_ff.strapCnt + 2'h1;
        end
        if (strapLoad) begin
            nxt_st.gc1[`SGC_GC1_TX_PAUSE_DIS] = strapSync[0];
            nxt_st.gc1[`SGC_GC1_RX_PAUSE_DIS] = strapSync[0];
            nxt_st.gc1[`SGC_GC1_BACKOFF] = strapSync[1];
            nxt_st.gc1[`SGC_GC1_AGING] = strapSync[2];
        end
        // Bus opens a cycle after the load, so no write races a strap
        if (st_ff.strapCnt == `SGC_STRAP_DONE_CNT) begin
            nxt_st.strapDone = 1'b1;
        end

        // Register access; ack is raised for one cycle, unmapped words too
        if (busReq) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdData = readReg(regIdx, st_ff.gc0, st_ff.gc1);
        end
        // Write while ack stands; bits 7:3 of the first register are not kept
        if (busWrite) begin
            if (regIdx == `SGC_IDX_GC0) begin
                nxt_st.gc0 = wb_dat_i[2:0];
            end else begin
                nxt_st.gc1 = wb_dat_i[7:0];
            end
        end

        // flush on any unplug
        // Link history feeds the per port fall detect
        nxt_st.linkPrev = linkUp;
        nxt_st.flushAll = linkDrop;

        // Age machine; a 33-bit counter covers the five minute period
        case (st_ff.ageState)
            AGE_OFF: begin
                // Counter held at zero so an enable starts a full period
                nxt_st.ageCnt = '0;
                if (st_ff.gc1[`SGC_GC1_AGING]) begin
                    nxt_st.ageState = AGE_NORMAL;
                end
            end
            AGE_NORMAL, AGE_FAST_ONCE: begin
                if (ageEnd) begin
                    nxt_st.ageCnt = '0;
                    nxt_st.ageTick = 1'b1;
                    nxt_st.ageState = AGE_NORMAL;
                end else begin
                    nxt_st.ageCnt = st_ff.ageCnt + `SGC_AGE_CNT_W'(1);
                end
                if (onceStart) begin
                    nxt_st.ageState = AGE_FAST_ONCE;
                    nxt_st.ageCnt = '0;
                end
                // Disable wins over a due tick or a pending fast cycle
                if (!st_ff.gc1[`SGC_GC1_AGING]) begin
                    nxt_st.ageState = AGE_OFF;
                    nxt_st.ageCnt = '0;
                    nxt_st.ageTick = 1'b0;
                end
            end
            default: begin
                // An unused code falls back to off
                nxt_st.ageState = AGE_OFF;
                nxt_st.ageCnt = '0;
            end
        endcase
        // Taken from the next state so the level lines up with the counter
        nxt_st.ageFast = (nxt_st.ageState != AGE_OFF) &&
                         (nxt_st.gc1[`SGC_GC1_FAST_AGE] || nxt_st.ageState == AGE_FAST_ONCE);

        // Gates are registered so the enables leave from flip-flops
        // transmit and receive pause gating
        nxt_st.txPause = txGate;
        nxt_st.rxPause = rxGate;

        // Frame verdict one cycle after the header strobe
        nxt_st.frmDone = frmValid;
        nxt_st.frmDrop = frmValid && dropNow;

        // per port buffer ceiling
        // Only a ceiling; the queue manager enforces it
        if (st_ff.gc0[`SGC_GC0_SHARE]) begin
            nxt_st.bufLimit = SHARED_LIMIT;
        end else begin
            nxt_st.bufLimit = SPLIT_LIMIT;
        end
    end

    // Reset takes documented pull defaults; straps overwrite the pause disable, back off and aging bits after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{
                strapCnt: 2'h0,
                strapDone: 1'b0,
                gc0: `SGC_GC0_RST,
                gc1: `SGC_GC1_RST,
                ack: 1'b0,
                rdData: 8'h00,
                linkPrev: '0,
                flushAll: 1'b0,
                ageState: AGE_OFF,
                ageCnt: '0,
                ageTick: 1'b0,
                ageFast: 1'b0,
                txPause: '0,
                rxPause: '0,
                frmDone: 1'b0,
                frmDrop: 1'b0,
                bufLimit: 16'h0000
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = {24'h000000, st_ff.rdData};

    // Frame verdict pulses
    assign frmDone = st_ff.frmDone;
    assign frmDrop = st_ff.frmDrop;

    // Policy levels
    assign portBufLimit = st_ff.bufLimit;
    assign bufShareEn = st_ff.gc0[`SGC_GC0_SHARE];
    assign passAllFrames = st_ff.gc1[`SGC_GC1_PASS_ALL];
    assign aggressiveBackoff = st_ff.gc1[`SGC_GC1_BACKOFF];
    assign txPauseEn = st_ff.txPause;
    assign rxPauseEn = st_ff.rxPause;

    // Aging controls
    assign agingEn = st_ff.gc1[`SGC_GC1_AGING];
    assign ageTick = st_ff.ageTick;
    assign ageFast = st_ff.ageFast;
    assign ageFlushAll = st_ff.flushAll;
endmodule // sgc_global_ctrl

// ### rtl/sgc_pkg.sv
// Types shared by the global control block
`include "sgc_consts.svh"

package sgc_pkg;

    typedef logic [`SGC_NUM_PORTS-1:0] sgc_port_t;
    typedef logic [`SGC_AGE_CNT_W-1:0] sgc_age_cnt_t;

    typedef enum logic [1:0] {
        AGE_OFF = 2'b00,
        AGE_NORMAL = 2'b01,
        AGE_FAST_ONCE = 2'b10
    } sgc_age_e;

    typedef struct packed {
        logic [1:0] strapCnt;
        logic strapDone;
        logic [2:0] gc0;
        logic [7:0] gc1;
        logic ack;
        logic [7:0] rdData;
        sgc_port_t linkPrev;
        logic flushAll;
        sgc_age_e ageState;
        sgc_age_cnt_t ageCnt;
        logic ageTick;
        logic ageFast;
        sgc_port_t txPause;
        sgc_port_t rxPause;
        logic frmDone;
        logic frmDrop;
        logic [15:0] bufLimit;
    } sgc_state_s;

endpackage

// ### rtl/sgc_sync.sv
// Two flip-flop synchroniser for pin levels
module sgc_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sgc_sync_s;

    sgc_sync_s st_ff;
    sgc_sync_s nxt_st;

    // First stage feeds only the second stage
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stage1 = asyncIn;
        nxt_st.stage2 = st_ff.stage1;
    end

    // Both stages clear under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign syncOut = st_ff.stage2;
endmodule // sgc_sync

// ### verification/sgc_global_ctrl_asserts.sv
// Port checks for the global control block
module sgc_global_ctrl_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic frmValid,
    input wire logic frmDone,
    input wire logic frmDrop,
    input wire logic passAllFrames,
    input wire sgc_pkg::sgc_port_t linkUp,
    input wire sgc_pkg::sgc_port_t anTxPause,
    input wire sgc_pkg::sgc_port_t anRxPause,
    input wire sgc_pkg::sgc_port_t txPauseEn,
    input wire sgc_pkg::sgc_port_t rxPauseEn,
    input wire logic ageFlushAll,
    input wire logic ageTick,
    input wire logic agingEn
);
    import sgc_pkg::*;

    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Steps of a bus request and of a port losing its link
    sequence busReq;
        wb_cyc_i && wb_stb_i;
    endsequence
    sequence linkDrop;
        |($past(linkUp) & ~linkUp);
    endsequence

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_frm_answer: assert property (frmValid |=> frmDone) else $error("verdict late");
    a_drop_done: assert property (frmDrop |-> frmDone) else $error("drop without done");
    a_pass_all: assert property (frmValid && passAllFrames |=> !frmDrop)
        else $error("frame dropped in pass all");
    a_link_flush: assert property (linkDrop |=> ageFlushAll)
        else $error("no flush on link drop");
    a_tx_gate: assert property ((txPauseEn & ~$past(anTxPause)) == 5'h0)
        else $error("tx pause without negotiation");
    a_rx_gate: assert property ((rxPauseEn & ~$past(anRxPause)) == 5'h0)
        else $error("rx pause without negotiation");
    a_age_off: assert property (!agingEn [*3] |-> !ageTick)
        else $error("tick while aging off");
    a_tick_pulse: assert property (ageTick |=> !ageTick) else $error("tick too long");
    c_bus: cover property (busReq ##1 wb_ack_o);
endmodule // sgc_global_ctrl_asserts

bind sgc_global_ctrl sgc_global_ctrl_asserts sgc_global_ctrl_asserts_inst (.*);

// ### verification/tb.sv
// Register, frame and aging tests of the global control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sgc_pkg::*;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, frmV = 0, fErr = 0, fPq = 0;
    logic pStrap = 1, bStrap = 1, aStrap = 0;
    logic [7:0] adr = 8'h0, rd;
    logic [3:0] sel = 4'hf;
    logic [31:0] datI = 32'h0, datO;
    sgc_port_t link = 5'h1f, anTx = 5'h1f, anRx = 5'h1f, txEn, rxEn;
    logic [15:0] fTl = 16'h0, fLen = 16'h0, bufLim;
    logic [47:0] fDa = 48'h0;
    logic ack, fDone, fDrop, share, passAll, aggBo, ageEn, tick, fast, flush;
    int fails = 0, totalChecks = 0, n;

    // Short age periods keep the run brief
    sgc_global_ctrl #(.NORMAL_AGE_CYC(33'd40), .FAST_AGE_CYC(33'd10)) sgc_global_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .pause_disable_strap_pin(pStrap), .backoff_strap_pin(bStrap),
        .aging_strap_pin(aStrap), .linkUp(link), .anTxPause(anTx), .anRxPause(anRx),
        .frmValid(frmV), .frmTypeLen(fTl), .frmDstAddr(fDa), .frmLen(fLen), .frmErr(fErr),
        .frmPauseQual(fPq), .frmDone(fDone), .frmDrop(fDrop), .portBufLimit(bufLim),
        .bufShareEn(share), .passAllFrames(passAll), .aggressiveBackoff(aggBo),
        .txPauseEn(txEn), .rxPauseEn(rxEn), .agingEn(ageEn), .ageTick(tick),
        .ageFast(fast), .ageFlushAll(flush));

    // Clock
    always #25 clk = ~clk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Classic cycle; waits for ack, only the watchdog ends a hang
    task wbx(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task rdc(input logic [7:0] a, input logic [7:0] e);
        wbx(1'b0, a, 8'h0);
        chk(32'(rd), 32'(e));
    endtask

    task frame(input logic [15:0] tl, input logic [47:0] da, input logic [15:0] len,
               input logic err, input logic pq, input logic e);
        @(posedge clk);
        frmV <= 1'b1;
        fTl <= tl;
        fDa <= da;
        fLen <= len;
        fErr <= err;
        fPq <= pq;
        @(posedge clk);
        frmV <= 1'b0;
        @(posedge clk);
        chk(32'({fDone, fDrop}), {30'h0, 1'b1, e});
    endtask

    // Cycles between two ticks; 60 means none came
    task gap(output int g);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (tick !== 1'b1 && k < 60);
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (tick !== 1'b1 && g < 60);
    endtask

    task wrap_up;
        $display("checks=%0d fails=%0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog at 10000 cycles, well beyond the few hundred cycles needed
    initial begin
        #500000;
        fails++;
        wrap_up();
    end

    // Main sequence; straps flip after capture and must not leak in
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        pStrap <= 1'b0;
        bStrap <= 1'b0;
        aStrap <= 1'b1;
        chk(32'({bufLim, share, ageEn, aggBo}), 32'({16'd500, 3'b101}));
        rdc(8'h08, 8'h04);
        rdc(8'h0c, 8'h31);
        wbx(1'b1, 8'h0c, 8'h10);
        repeat (2) @(posedge clk);
        chk(32'({txEn, rxEn}), 32'h3e0);
        anTx <= 5'h0a;
        anRx <= 5'h15;
        repeat (2) @(posedge clk);
        chk(32'({txEn, rxEn}), 32'h140);
        wbx(1'b1, 8'h0c, 8'h20);
        repeat (2) @(posedge clk);
        chk(32'({txEn, rxEn}), 32'h015);
        wbx(1'b1, 8'h08, 8'hff);
        rdc(8'h08, 8'h07);
        rdc(8'h10, 8'h00);
        sel <= 4'h0;
        wbx(1'b1, 8'h08, 8'h00);
        sel <= 4'hf;
        rdc(8'h08, 8'h07);
        wbx(1'b1, 8'h08, 8'h00);
        repeat (2) @(posedge clk);
        chk(32'({bufLim, share}), 32'({16'd100, 1'b0}));
        frame(16'h8808, 48'h0, 16'h0, 1'b0, 1'b0, 1'b0);
        frame(16'h0800, 48'h0, 16'h0, 1'b0, 1'b1, 1'b1);
        frame(16'h0800, 48'h0, 16'h0, 1'b1, 1'b0, 1'b1);
        wbx(1'b1, 8'h08, 8'h02);
        frame(16'h8808, 48'h0, 16'h0, 1'b0, 1'b0, 1'b1);
        frame(16'h0800, 48'h0180c2000001, 16'h0, 1'b0, 1'b0, 1'b1);
        frame(16'h0800, 48'h0180c2000002, 16'h0, 1'b0, 1'b1, 1'b0);
        wbx(1'b1, 8'h0c, 8'h08);
        frame(16'd100, 48'h0, 16'd99, 1'b0, 1'b0, 1'b1);
        frame(16'd100, 48'h0, 16'd100, 1'b0, 1'b0, 1'b0);
        frame(16'd1500, 48'h0, 16'd7, 1'b0, 1'b0, 1'b0);
        wbx(1'b1, 8'h0c, 8'h88);
        frame(16'h8808, 48'h0, 16'h0, 1'b1, 1'b1, 1'b0);
        wbx(1'b1, 8'h0c, 8'h04);
        gap(n);
        chk(32'(n), 32'd40);
        wbx(1'b1, 8'h0c, 8'h06);
        gap(n);
        gap(n);
        chk(32'(n), 32'd10);
        wbx(1'b1, 8'h0c, 8'h00);
        repeat (3) @(posedge clk);
        gap(n);
        chk(32'(n), 32'd60);
        wbx(1'b1, 8'h0c, 8'h04);
        wbx(1'b1, 8'h08, 8'h05);
        @(posedge clk);
        link <= 5'h1b;
        repeat (2) @(posedge clk);
        chk(32'({flush, fast}), 32'h3);
        gap(n);
        chk(32'(n), 32'd40);
        wrap_up();
    end
endmodule // tb
